// *** design/sram_ctrl.sv ***
// Controller that drives a clockless 64K x 4 static memory through its pins
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"

// Contract
// (R01) Memory holds 65536 four-bit words on sixteen address lines.
// (R02) Select low with strobe high reads the addressed word.
// (R03) Write only while select and strobe low; controller drives data then.
// (R04) Select and strobe rising together leaves memory outputs floating.
// (R05) Address valid no later than select falling, strobe high, for reads.
// (R06) Read cycles last at least 15 ns address to address.
// (R07) Read data valid within 15 ns after select with stable address.
// (R08) Old read data held at least 2 ns after address change.
// (R09) Memory starts driving no sooner than 2 ns after select.
// (R10) Memory floats within 8 ns after deselect.
// (R11) Standby within 15 ns after deselect; powers up at once.
// (R12) Write cycles last at least 13 ns address to address.
// (R13) Address valid 12 ns before write end; may change right after.
// (R14) Select held low at least 12 ns up to write end.
// (R15) Data stable 7 ns before write end; may drop right after.
// (R16) Strobe falling floats memory outputs within 6 ns.
// (R17) After write end, memory drives again no sooner than 2 ns.
// (R18) Write ends at first of select or strobe rising; data stored then.
module sram_ctrl
   import sram_ctrl_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int DATA_W = `DATA_W
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_req,
   input  wire logic              i_we,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   output logic                   o_busy,
   output logic                   o_rvalid,
   output logic [DATA_W-1:0]      o_rdata,
   output logic                   o_wdone,
   output logic [ADDR_W-1:0]      o_mem_addr,
   output logic                   o_mem_cs_n,
   output logic                   o_mem_we_n,
   output logic [DATA_W-1:0]      o_mem_dq_o,
   output logic                   o_mem_dq_oe,
   input  wire logic [DATA_W-1:0] i_mem_dq
);
   import sram_ctrl_pkg::*;

   // Step counts in whole clock cycles
   localparam logic [3:0] RD_CYC  = 4'(`READ_ACCESS_CYC);
   localparam logic [3:0] WP_CYC  = 4'(`WRITE_PULSE_CYC);
   localparam logic [3:0] FLT_CYC = 4'(`FLOAT_CYC);

   // Controller state, apart from the two pin flops, lives in one struct
   ctrl_regs_t r_r;
   ctrl_regs_t r_nxt;

   // Pin flops for the memory data word
   logic [DATA_W-1:0] dq_sync1_r;
   logic [DATA_W-1:0] dq_sync2_r;

   // Data pins come from a clockless part; two flops before use.
   // Bits may land a cycle apart, but the word is taken only after
   // it has stood still on the pins for several cycles.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dq_sync1_r <= `RST_DATA;
         dq_sync2_r <= `RST_DATA;
      end else begin
         dq_sync1_r <= i_mem_dq;
         dq_sync2_r <= dq_sync1_r;
      end
   end

   // Read, one step per cycle (N = RD_CYC):
   //   take edge     address and select move together, strobe high
   //   +1 .. +N      access count runs down, word settles on the pins
   //   +N+1, +N+2    word passes the two pin flops
   //   +N+3          word taken, read valid pulses, select released
   //   +N+4, +N+5    float gap, then back to idle
   // Write, one step per cycle (M = WP_CYC):
   //   take edge     address and data latched, strobe still high
   //   +1            select and strobe fall, memory lets go of the pins
   //   +2 .. +M+1    data driven, pulse count runs down
   //   +M+2          select and strobe rise together, data still driven
   //   +M+3          data released, write done pulses
   //   +M+4, +M+5    float gap, then back to idle
   // Every step is a whole cycle, far above each ns minimum.
   // Pin data only drives a cycle after the strobe fell, so the
   // memory has floated and the two sides never fight.
   // Ending on select and strobe together keeps the memory floating;
   // ending on the strobe alone would let it drive into our data.
   // Requests while busy are dropped without notice; callers
   // wait for busy to fall before the next one.
   // Cost of the whole-cycle steps: a word every seven cycles.

   // Next-state logic for the whole controller
   always_comb begin
      r_nxt        = r_r;
      r_nxt.rvalid = 1'b0;
      r_nxt.wdone  = 1'b0;
      unique case (r_r.state)
         ST_IDLE: begin
            r_nxt.busy = 1'b0;
            if (i_req) begin
               r_nxt.busy  = 1'b1;
               r_nxt.addr  = i_addr;                 // (R01)
               r_nxt.wdata = i_wdata;
               r_nxt.we_n  = 1'b1;                   // (R05)
               if (i_we) begin
                  // Address settles a cycle before strobe falls
                  r_nxt.state = ST_WR_SET;
               end else begin
                  r_nxt.cs_n  = 1'b0;                // (R02)
                  r_nxt.cnt   = RD_CYC;
                  r_nxt.state = ST_RD_ACC;
               end
            end
         end

         ST_RD_ACC: begin
            // Sync delay adds two cycles on top of access, covers (R07)
            if (r_r.cnt != 4'h0) begin
               r_nxt.cnt = r_r.cnt - 4'h1;           // (R06)
            end else begin
               r_nxt.state = ST_RD_END;
            end
         end

         ST_RD_END: begin
            // Wait out the second pin flop
            r_nxt.cnt = r_r.cnt + 4'h1;
            if (r_r.cnt == 4'h1) begin
               r_nxt.rdata  = dq_sync2_r;
               r_nxt.rvalid = 1'b1;
               r_nxt.cs_n   = 1'b1;
               r_nxt.cnt    = FLT_CYC;
               r_nxt.state  = ST_TURN;               // (R10)
            end
         end

         ST_WR_SET: begin
            r_nxt.cs_n  = 1'b0;
            r_nxt.we_n  = 1'b0;                      // (R03)
            r_nxt.cnt   = WP_CYC;
            r_nxt.state = ST_WR_PULSE;
         end

         ST_WR_PULSE: begin
            // Drive only after strobe fell so the memory has floated
            r_nxt.dq_oe = 1'b1;                      // (R16)
            if (r_r.cnt != 4'h0) begin
               r_nxt.cnt = r_r.cnt - 4'h1;           // (R14)
            end else if (r_r.dq_oe) begin
               // Data has stood a full cycle, above 7 ns
               r_nxt.we_n  = 1'b1;                   // (R15)
               r_nxt.cs_n  = 1'b1;                   // (R18)
               r_nxt.state = ST_WR_END;
            end
         end

         ST_WR_END: begin
            // Hold address and data one cycle past the write end
            r_nxt.dq_oe = 1'b0;                      // (R13)
            r_nxt.wdone = 1'b1;
            r_nxt.cnt   = FLT_CYC;
            r_nxt.state = ST_TURN;                   // (R12)
         end

         ST_TURN: begin
            // Turnaround gap keeps the next cycle off a floating bus
            if (r_r.cnt != 4'h0) begin
               r_nxt.cnt = r_r.cnt - 4'h1;           // (R04)
            end else begin
               r_nxt.busy  = 1'b0;
               r_nxt.state = ST_IDLE;
            end
         end

         default: begin
            // Illegal code; park the pins safely
            r_nxt.state = ST_IDLE;
            r_nxt.cs_n  = 1'b1;
            r_nxt.we_n  = 1'b1;
            r_nxt.dq_oe = 1'b0;
         end
      endcase
   end

   // State register; reset parks the memory deselected and floating
   // Reset clears the controller registers and pins, never the stored words
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r_r.state  <= ST_IDLE;
         r_r.cnt    <= 4'h0;
         r_r.addr   <= `RST_ADDR;
         r_r.wdata  <= `RST_DATA;
         r_r.rdata  <= `RST_DATA;
         r_r.cs_n   <= 1'b1;
         r_r.we_n   <= 1'b1;
         r_r.dq_oe  <= 1'b0;
         r_r.busy   <= 1'b0;
         r_r.rvalid <= 1'b0;
         r_r.wdone  <= 1'b0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // Handshake outputs straight from flops
   assign o_busy      = r_r.busy;
   assign o_rvalid    = r_r.rvalid;
   assign o_rdata     = r_r.rdata;
   assign o_wdone     = r_r.wdone;

   // Memory pins straight from flops; select and strobe reset high
   assign o_mem_addr  = r_r.addr;
   assign o_mem_cs_n  = r_r.cs_n;
   assign o_mem_we_n  = r_r.we_n;
   assign o_mem_dq_o  = r_r.wdata;
   assign o_mem_dq_oe = r_r.dq_oe;
endmodule : sram_ctrl

// *** design/sram_ctrl_map.svh ***
// Timing, width and reset constants for the static memory controller
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH
`define SYS_CLK_PERIOD_NS        100
`define READ_CYCLE_MIN_NS        15
`define SELECT_ACCESS_DELAY_NS   15
`define DESELECT_TO_FLOAT_NS     8
`define STROBE_TO_FLOAT_NS       6
`define WRITE_CYCLE_MIN_NS       13
`define WRITE_PULSE_MIN_NS       12
`define DATA_SETUP_MIN_NS        7
// Least times round up, never below one cycle
`define CYC_UP(ns) ((((ns) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS))
`define READ_ACCESS_CYC  `CYC_UP(`SELECT_ACCESS_DELAY_NS + `READ_CYCLE_MIN_NS)
`define WRITE_PULSE_CYC  `CYC_UP(`WRITE_PULSE_MIN_NS)
`define WRITE_DATA_CYC   `CYC_UP(`DATA_SETUP_MIN_NS)
`define FLOAT_CYC        `CYC_UP(`DESELECT_TO_FLOAT_NS)
`define ADDR_W           16
`define DATA_W           4
`define RST_ADDR         16'h0000
`define RST_DATA         4'h0
`endif

// *** design/sram_ctrl_pkg.sv ***
// Types for the static memory controller
package sram_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_ACC,
      ST_RD_END,
      ST_WR_SET,
      ST_WR_PULSE,
      ST_WR_END,
      ST_TURN
   } ctrl_state_t;

   typedef struct packed {
      ctrl_state_t state;
      logic [3:0]  cnt;
      logic [15:0] addr;
      logic [3:0]  wdata;
      logic [3:0]  rdata;
      logic        cs_n;
      logic        we_n;
      logic        dq_oe;
      logic        busy;
      logic        rvalid;
      logic        wdone;
   } ctrl_regs_t;
endpackage : sram_ctrl_pkg

// *** tb/async_sram_64kx4_port_tb_top.sv ***
// Random traffic through the controller into a memory model
`timescale 1ns/1ps
`include "sram_ctrl_map.svh"
module async_sram_64kx4_port_tb_top;
   logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_we = 1'b0;
   logic o_busy, o_rvalid, o_wdone, o_mem_cs_n, o_mem_we_n, o_mem_dq_oe;
   logic [15:0] i_addr = 16'h0000, o_mem_addr;
   logic [3:0] i_wdata = 4'h0, o_rdata, o_mem_dq_o, i_mem_dq, mdq, ref_m [int];
   int mismatches = 0, checks_done = 0, seed = 32'h6CF4FA17, n;
   // Clock; controller wins the wire while enabled
   always #50 i_sys_clk = ~i_sys_clk;
   assign i_mem_dq = o_mem_dq_oe ? o_mem_dq_o : mdq;
   sram_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req(i_req), .i_we(i_we),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_rvalid(o_rvalid),
      .o_rdata(o_rdata), .o_wdone(o_wdone), .o_mem_addr(o_mem_addr),
      .o_mem_cs_n(o_mem_cs_n), .o_mem_we_n(o_mem_we_n), .o_mem_dq_o(o_mem_dq_o),
      .o_mem_dq_oe(o_mem_dq_oe), .i_mem_dq(i_mem_dq));
   sram_model mem_u (.i_addr(o_mem_addr), .i_cs_n(o_mem_cs_n), .i_we_n(o_mem_we_n),
      .i_dq(i_mem_dq), .o_dq(mdq));
   // Window of 16 words holding both end addresses
   function automatic logic [15:0] win(logic [3:0] k);
      return k[3] ? {12'hFFF, k} : {12'h000, k};
   endfunction : win
   task automatic check(string s, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   // One request; a poke while busy must be ignored
   task automatic op(logic w, logic [15:0] a, logic [3:0] d, logic p);
      while (o_busy !== 1'b0) @(posedge i_sys_clk) #1;
      {i_req, i_we, i_addr, i_wdata} = {1'b1, w, a, d};
      for (n = 0; (w ? o_wdone : o_rvalid) !== 1'b1 && n < 20; n++) begin
         @(posedge i_sys_clk) #1;
         i_req = p && n == 1;
      end
      // Writes add take, set-up, end and done steps; reads add take, count-end and two flop steps: four edges each
      check("latency", 8'(n), w ? 8'(`WRITE_PULSE_CYC + 4) : 8'(`READ_ACCESS_CYC + 4));
      if (w) ref_m[a] = d;
      else check("rdata", o_rdata, ref_m[a]);
   endtask : op
   // Fill the window, then a random mix
   initial begin
      repeat (10) @(posedge i_sys_clk);
      #1 i_nrst = 1'b1;
      for (int i = 0; i < 16; i++) op(1'b1, win(4'(i)), 4'($random(seed)), 1'b1);
      repeat (70) op(1'($random(seed)), win(4'($random(seed))), 4'($random(seed)), 1'b1);
      stop_test();
   end
   // Watchdog far past the expected run
   initial begin
      #400000;
      mismatches++;
      stop_test();
   end
endmodule : async_sram_64kx4_port_tb_top

// *** tb/sram_ctrl_asserts.sv ***
// Pin-order checks for the static memory controller
`timescale 1ns/1ps
module sram_ctrl_asserts (
   input wire logic i_sys_clk, i_nrst, i_req, o_busy, o_rvalid, o_wdone,
   input wire logic o_mem_cs_n, o_mem_we_n, o_mem_dq_oe,
   input wire logic [15:0] o_mem_addr,
   input wire logic [3:0] o_mem_dq_o);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // Strobe low two cycles (pulse count plus one), then the write ends
   sequence s_pulse; !o_mem_we_n [*2] ##1 o_mem_we_n; endsequence
   property p_take; i_req && !o_busy |=> o_busy; endproperty
   a_take: assert property (p_take) else $error("take");
   property p_rd; $fell(o_mem_cs_n) && o_mem_we_n |-> ##4 o_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_wr; $fell(o_mem_we_n) |-> s_pulse ##1 o_wdone; endproperty
   a_wr: assert property (p_wr) else $error("pulse");
   property p_wecs; !o_mem_we_n |-> !o_mem_cs_n; endproperty
   a_wecs: assert property (p_wecs) else $error("strobe");
   property p_end; $rose(o_mem_we_n) |-> $rose(o_mem_cs_n); endproperty
   a_end: assert property (p_end) else $error("end");
   property p_addr; !o_mem_cs_n && $past(!o_mem_cs_n) |-> $stable(o_mem_addr); endproperty
   a_addr: assert property (p_addr) else $error("addr");
   property p_data; $rose(o_mem_we_n) |-> o_mem_dq_oe && $stable(o_mem_dq_o); endproperty
   a_data: assert property (p_data) else $error("data");
   property p_oe; o_mem_dq_oe |-> !o_mem_we_n || $past(!o_mem_we_n); endproperty
   a_oe: assert property (p_oe) else $error("drive");
endmodule : sram_ctrl_asserts

bind sram_ctrl sram_ctrl_asserts chk_u (.i_sys_clk, .i_nrst, .i_req, .o_busy, .o_rvalid,
   .o_wdone, .o_mem_cs_n, .o_mem_we_n, .o_mem_dq_oe, .o_mem_addr, .o_mem_dq_o);

// *** tb/sram_model.sv ***
// Behavioural 64K x 4 static memory
`timescale 1ns/1ps
module sram_model (
   input  wire logic [15:0] i_addr,
   input  wire logic        i_cs_n,
   input  wire logic        i_we_n,
   input  wire logic [3:0]  i_dq,
   output logic      [3:0]  o_dq);
   logic [3:0]  mem [65536];
   logic [3:0]  wd;
   logic [15:0] wa;
   logic        armed = 1'b0;
   logic        powered = 1'b0;
   // Full power at once on select, standby 15 ns after release
   always @(i_cs_n)
      powered <= #(i_cs_n ? 15 : 0) !i_cs_n;
   // Store at whichever of select or strobe rises first
   always @(i_cs_n, i_we_n, i_addr, i_dq)
      if (!i_cs_n && !i_we_n) begin
         {armed, wa, wd} = {1'b1, i_addr, i_dq};
      end else if (armed && powered) begin
         mem[wa] = wd;
         armed = 1'b0;
      end
   // Floating pins flip to the inverse on each select, strobe or address change
   initial o_dq = 4'h5;
   always @(i_cs_n, i_we_n, i_addr)
      o_dq <= #6 (!i_cs_n && i_we_n) ? mem[i_addr] : ~o_dq;
endmodule : sram_model
